// [ctm_pkg.sv]
// shared types and constants for the counter/timer block
package ctm_pkg;

    localparam int unsigned CNT_W     = 32;
    localparam int unsigned NUM_MATCH = 4;
    localparam int unsigned NUM_CAP   = 2;
    localparam int unsigned NUM_EXT   = 2;
    localparam int unsigned NUM_DMA   = 2;
    localparam int unsigned IRQ_W     = NUM_MATCH + NUM_CAP;

    localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_ONE  = 32'h0000_0001;

    // count source select
    typedef enum logic [1:0] {
        SRC_BUS_CLK  = 2'b00,
        SRC_CAP_RISE = 2'b01,
        SRC_CAP_FALL = 2'b10,
        SRC_CAP_BOTH = 2'b11
    } count_src_t;

    // external match output action
    typedef enum logic [1:0] {
        EXT_NOTHING = 2'b00,
        EXT_LOW     = 2'b01,
        EXT_HIGH    = 2'b10,
        EXT_TOGGLE  = 2'b11
    } ext_act_t;

    // per match register control
    typedef struct packed {
        logic irq_en;
        logic reset_en;
        logic stop_en;
    } match_ctl_t;

    // per capture channel control
    typedef struct packed {
        logic irq_en;
        logic on_fall;
        logic on_rise;
    } cap_ctl_t;

    // clear-on-capture control
    typedef struct packed {
        logic       en;
        logic       chan;
        logic       on_fall;
    } clr_ctl_t;

    // timer state machine
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_RUN     = 2'b01,
        ST_STOPPED = 2'b10
    } tmr_state_t;

endpackage : ctm_pkg

// [edge_sync.sv]
// two-flop synchroniser with edge detection for one pin
`timescale 1ns/1ps
`default_nettype none

module edge_sync (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic pin_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);

    logic meta_q;
    logic sync_q;
    logic last_q;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign level_o = sync_q;
    assign rise_o  = sync_q & ~last_q;
    assign fall_o  = ~sync_q & last_q;

endmodule : edge_sync

`default_nettype wire

// [prescaler.sv]
// programmable prescaler producing a one-cycle count enable
`timescale 1ns/1ps
`default_nettype none

module prescaler (
    input  wire logic                     clk_i,
    input  wire logic                     nrst_i,
    input  wire logic                     run_i,
    input  wire logic                     tick_i,
    input  wire logic                     clear_i,
    input  wire logic [ctm_pkg::CNT_W-1:0] limit_i,
    output logic      [ctm_pkg::CNT_W-1:0] value_o,
    output logic                          step_o
);

    logic [ctm_pkg::CNT_W-1:0] pc_q;
    logic [ctm_pkg::CNT_W-1:0] pc_d;
    logic                      wrap;

    // terminal value reached: wrap and emit one count step
    assign wrap   = run_i & tick_i & (pc_q >= limit_i);
    assign step_o = wrap;
    assign value_o = pc_q;

    always_comb begin
        pc_d = pc_q;
        if (clear_i) begin
            pc_d = ctm_pkg::CNT_ZERO;
        end else if (wrap) begin
            pc_d = ctm_pkg::CNT_ZERO;
        end else if (run_i && tick_i) begin
            pc_d = pc_q + ctm_pkg::CNT_ONE;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pc_q <= ctm_pkg::CNT_ZERO;
        end else begin
            pc_q <= pc_d;
        end
    end

endmodule : prescaler

`default_nettype wire

// [counter_timer_capture_match.sv]
// 32-bit counter/timer with prescaler, capture channels and match logic
`timescale 1ns/1ps
`default_nettype none

module counter_timer_capture_match (
    input  wire logic                                         clk_i,
    input  wire logic                                         nrst_i,
    // control
    input  wire logic                                         enable_i,
    input  wire logic                                         sw_reset_i,
    input  wire ctm_pkg::count_src_t                          count_src_i,
    input  wire logic                                         count_chan_i,
    input  wire logic [ctm_pkg::CNT_W-1:0]                    prescale_i,
    input  wire logic [ctm_pkg::NUM_MATCH-1:0][ctm_pkg::CNT_W-1:0] match_val_i,
    input  wire ctm_pkg::match_ctl_t [ctm_pkg::NUM_MATCH-1:0] match_ctl_i,
    input  wire ctm_pkg::cap_ctl_t [ctm_pkg::NUM_CAP-1:0]     cap_ctl_i,
    input  wire ctm_pkg::clr_ctl_t                            clr_ctl_i,
    input  wire ctm_pkg::ext_act_t [ctm_pkg::NUM_EXT-1:0]     ext_act_i,
    input  wire logic [ctm_pkg::IRQ_W-1:0]                    irq_clear_i,
    // pins
    input  wire logic [ctm_pkg::NUM_CAP-1:0]                  cap_pin_i,
    // status
    output logic      [ctm_pkg::CNT_W-1:0]                    timer_count_value_o,
    output logic      [ctm_pkg::CNT_W-1:0]                    prescale_count_o,
    output logic      [ctm_pkg::NUM_CAP-1:0][ctm_pkg::CNT_W-1:0] cap_val_o,
    output logic      [ctm_pkg::IRQ_W-1:0]                    irq_pending_o,
    output logic                                              running_o,
    output logic      [ctm_pkg::NUM_EXT-1:0]                  match_pin_o,
    output logic      [ctm_pkg::NUM_DMA-1:0]                  dma_req_o
);

    // ----------------------------------------------------------------
    // capture pin synchronisers
    // ----------------------------------------------------------------
    logic [ctm_pkg::NUM_CAP-1:0] cap_lvl;
    logic [ctm_pkg::NUM_CAP-1:0] cap_rise;
    logic [ctm_pkg::NUM_CAP-1:0] cap_fall;

    genvar gc;
    generate
        for (gc = 0; gc < ctm_pkg::NUM_CAP; gc++) begin : g_sync
            // each capture pin feeds its own channel and, when selected, the count source and capture clear
            edge_sync u_sync (
                .clk_i   (clk_i),
                .nrst_i  (nrst_i),
                .pin_i   (cap_pin_i[gc]),
                .level_o (cap_lvl[gc]),
                .rise_o  (cap_rise[gc]),
                .fall_o  (cap_fall[gc])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // count source
    // ----------------------------------------------------------------
    logic src_rise;
    logic src_fall;
    logic tick;

    assign src_rise = cap_rise[count_chan_i];
    assign src_fall = cap_fall[count_chan_i];

    always_comb begin
        case (count_src_i)
            ctm_pkg::SRC_BUS_CLK:  tick = 1'b1;
            ctm_pkg::SRC_CAP_RISE: tick = src_rise;
            ctm_pkg::SRC_CAP_FALL: tick = src_fall;
            ctm_pkg::SRC_CAP_BOTH: tick = src_rise | src_fall;
            default:               tick = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // timer state machine
    // ----------------------------------------------------------------
    ctm_pkg::tmr_state_t state_q;
    ctm_pkg::tmr_state_t state_d;
    logic                run;
    logic                step;
    logic                cap_clear;
    logic [ctm_pkg::CNT_W-1:0] tc_q;
    logic [ctm_pkg::CNT_W-1:0] tc_d;
    logic [ctm_pkg::CNT_W-1:0] pc_val;

    // ----------------------------------------------------------------
    // capture clear of count and prescaler
    // ----------------------------------------------------------------
    logic clr_rise;
    logic clr_fall;

    assign clr_rise  = cap_rise[clr_ctl_i.chan];
    assign clr_fall  = cap_fall[clr_ctl_i.chan];
    assign cap_clear = clr_ctl_i.en & (clr_ctl_i.on_fall ? clr_fall : clr_rise);

    assign run = (state_q == ctm_pkg::ST_RUN);

    prescaler u_pre (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .run_i   (run),
        .tick_i  (tick),
        .clear_i (sw_reset_i | cap_clear),
        .limit_i (prescale_i),
        .value_o (pc_val),
        .step_o  (step)
    );

    // ----------------------------------------------------------------
    // match detection
    // ----------------------------------------------------------------
    logic [ctm_pkg::NUM_MATCH-1:0] match_hit;
    logic [ctm_pkg::NUM_MATCH-1:0] match_stop;
    logic [ctm_pkg::NUM_MATCH-1:0] match_rst;
    logic [ctm_pkg::NUM_MATCH-1:0] match_irq;
    logic [ctm_pkg::NUM_MATCH-1:0] match_seen_q;
    logic [ctm_pkg::NUM_MATCH-1:0] match_new;

    genvar gm;
    generate
        for (gm = 0; gm < ctm_pkg::NUM_MATCH; gm++) begin : g_match
            assign match_hit[gm]  = run & (tc_q == match_val_i[gm]);
            assign match_new[gm]  = match_hit[gm] & ~match_seen_q[gm];
            assign match_stop[gm] = match_new[gm] & match_ctl_i[gm].stop_en;
            assign match_rst[gm]  = match_hit[gm] & match_ctl_i[gm].reset_en & step;
            assign match_irq[gm]  = match_new[gm] & match_ctl_i[gm].irq_en;
        end
    endgenerate

    // one event per arrival at a match value, not per cycle spent there
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            match_seen_q <= '0;
        end else begin
            match_seen_q <= match_hit;
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            ctm_pkg::ST_IDLE: begin
                if (enable_i && !sw_reset_i) begin
                    state_d = ctm_pkg::ST_RUN;
                end
            end
            ctm_pkg::ST_RUN: begin
                if (!enable_i) begin
                    state_d = ctm_pkg::ST_IDLE;
                end else if (|match_stop) begin
                    state_d = ctm_pkg::ST_STOPPED;
                end
            end
            ctm_pkg::ST_STOPPED: begin
                if (!enable_i) begin
                    state_d = ctm_pkg::ST_IDLE;
                end
            end
            default: state_d = ctm_pkg::ST_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // timer count
    // ----------------------------------------------------------------
    always_comb begin
        tc_d = tc_q;
        if (sw_reset_i || cap_clear) begin
            tc_d = ctm_pkg::CNT_ZERO;
        end else if (|match_rst) begin
            tc_d = ctm_pkg::CNT_ZERO;
        end else if (step && !(|match_stop)) begin
            tc_d = tc_q + ctm_pkg::CNT_ONE;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= ctm_pkg::ST_IDLE;
            tc_q    <= ctm_pkg::CNT_ZERO;
        end else begin
            state_q <= state_d;
            tc_q    <= tc_d;
        end
    end

    // ----------------------------------------------------------------
    // capture channels
    // ----------------------------------------------------------------
    logic [ctm_pkg::NUM_CAP-1:0] cap_evt;
    logic [ctm_pkg::NUM_CAP-1:0][ctm_pkg::CNT_W-1:0] cap_q;

    genvar gk;
    generate
        for (gk = 0; gk < ctm_pkg::NUM_CAP; gk++) begin : g_cap
            assign cap_evt[gk] = (cap_ctl_i[gk].on_rise & cap_rise[gk])
                               | (cap_ctl_i[gk].on_fall & cap_fall[gk]);
            always_ff @(posedge clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    cap_q[gk] <= ctm_pkg::CNT_ZERO;
                end else if (cap_evt[gk]) begin
                    cap_q[gk] <= tc_q;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // interrupt pending flags
    // ----------------------------------------------------------------
    logic [ctm_pkg::IRQ_W-1:0] irq_set;
    logic [ctm_pkg::IRQ_W-1:0] irq_q;
    logic [ctm_pkg::NUM_CAP-1:0] cap_irq;

    generate
        for (gk = 0; gk < ctm_pkg::NUM_CAP; gk++) begin : g_capirq
            assign cap_irq[gk] = cap_evt[gk] & cap_ctl_i[gk].irq_en;
        end
    endgenerate

    assign irq_set = {cap_irq, match_irq};

    // set wins over a same-cycle clear
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_q <= '0;
        end else begin
            irq_q <= (irq_q & ~irq_clear_i) | irq_set;
        end
    end

    // ----------------------------------------------------------------
    // external match pins and dma requests
    // ----------------------------------------------------------------
    logic [ctm_pkg::NUM_EXT-1:0] ext_q;
    logic [ctm_pkg::NUM_EXT-1:0] ext_d;
    logic [ctm_pkg::NUM_DMA-1:0] dma_q;

    genvar ge;
    generate
        for (ge = 0; ge < ctm_pkg::NUM_EXT; ge++) begin : g_ext
            always_comb begin
                ext_d[ge] = ext_q[ge];
                if (match_new[ge]) begin
                    case (ext_act_i[ge])
                        ctm_pkg::EXT_LOW:    ext_d[ge] = 1'b0;
                        ctm_pkg::EXT_HIGH:   ext_d[ge] = 1'b1;
                        ctm_pkg::EXT_TOGGLE: ext_d[ge] = ~ext_q[ge];
                        default:             ext_d[ge] = ext_q[ge];
                    endcase
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ext_q <= '0;
            dma_q <= '0;
        end else begin
            ext_q <= ext_d;
            dma_q <= match_new[ctm_pkg::NUM_DMA-1:0];
        end
    end

    // ----------------------------------------------------------------
    // registered status outputs
    // ----------------------------------------------------------------
    logic running_q;
    logic [ctm_pkg::CNT_W-1:0] pc_out_q;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            running_q <= 1'b0;
            pc_out_q  <= ctm_pkg::CNT_ZERO;
        end else begin
            running_q <= (state_d == ctm_pkg::ST_RUN);
            pc_out_q  <= pc_val;
        end
    end

    assign timer_count_value_o = tc_q;
    assign prescale_count_o    = pc_out_q;
    assign cap_val_o           = cap_q;
    assign irq_pending_o       = irq_q;
    assign running_o           = running_q;
    assign match_pin_o         = ext_q;
    assign dma_req_o           = dma_q;

endmodule : counter_timer_capture_match

`default_nettype wire

// [ctm_assertions.sv]
// concurrent checks on the counter/timer ports
`timescale 1ns/1ps
`default_nettype none
module ctm_assertions (
    input wire logic                                              clk_i,
    input wire logic                                              nrst_i,
    input wire logic                                              sw_reset_i,
    input wire logic [ctm_pkg::CNT_W-1:0]                         prescale_i,
    input wire logic [ctm_pkg::NUM_MATCH-1:0][ctm_pkg::CNT_W-1:0] match_val_i,
    input wire ctm_pkg::match_ctl_t [ctm_pkg::NUM_MATCH-1:0]      match_ctl_i,
    input wire ctm_pkg::cap_ctl_t [ctm_pkg::NUM_CAP-1:0]          cap_ctl_i,
    input wire ctm_pkg::clr_ctl_t                                 clr_ctl_i,
    input wire logic [ctm_pkg::IRQ_W-1:0]                         irq_clear_i,
    input wire logic [ctm_pkg::CNT_W-1:0]                         timer_count_value_o,
    input wire logic [ctm_pkg::IRQ_W-1:0]                         irq_pending_o,
    input wire logic                                              running_o,
    input wire logic [ctm_pkg::NUM_EXT-1:0]                       match_pin_o,
    input wire logic [ctm_pkg::NUM_DMA-1:0]                       dma_req_o
);
    logic [ctm_pkg::CNT_W-1:0] c;
    assign c = timer_count_value_o;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    AST_STEP: assert property (
        c != $past(c) |-> c == $past(c) + 32'h1 || c == 32'h0) else $error("count jumped");
    AST_SW_CLEAR: assert property (
        sw_reset_i |=> c == 32'h0) else $error("count not cleared");
    AST_IDLE_HOLD: assert property (
        !running_o && !sw_reset_i && !clr_ctl_i.en |=> c == $past(c)) else $error("count moved while idle");
    AST_STOP: assert property (
        running_o && c == match_val_i[0] && c != $past(c) && match_ctl_i[0].stop_en |-> ##[1:2] !running_o)
        else $error("stop match ignored");
    AST_RESET_MATCH: assert property (
        running_o && c == match_val_i[0] && match_ctl_i[0].reset_en && !match_ctl_i[0].stop_en && !sw_reset_i
        && !clr_ctl_i.en && prescale_i < 32'h6 |-> ##[1:8] c == 32'h0) else $error("reset match ignored");
    AST_MATCH_IRQ: assert property (
        running_o && c == match_val_i[0] && c != $past(c) && match_ctl_i[0].irq_en |=> irq_pending_o[0])
        else $error("match flag missing");
    AST_DMA_PULSE: assert property (
        dma_req_o[0] |=> !dma_req_o[0]) else $error("dma request too long");
    AST_DMA_CAUSE: assert property (
        $rose(dma_req_o[1]) |-> $past(c) == $past(match_val_i[1])) else $error("dma request without match");
    AST_IRQ_HOLD: assert property (
        $fell(irq_pending_o[5]) |-> $past(irq_clear_i[5])) else $error("flag dropped uncleared");
    AST_CAP_IRQ_GATED: assert property (
        $rose(irq_pending_o[4]) |-> $past(cap_ctl_i[0].irq_en)) else $error("capture flag while disabled");
    AST_PIN_CAUSE: assert property (
        $changed(match_pin_o[0]) |-> $past(c) == $past(match_val_i[0])) else $error("match pin moved");
    cover property (dma_req_o[0]);
    cover property ($rose(irq_pending_o[5]));
    cover property ($fell(running_o));
endmodule // ctm_assertions
`default_nettype wire

// [cap_pin_source.sv]
// model of the external signals feeding the capture pins
`timescale 1ns/1ps
`default_nettype none
module cap_pin_source (
    input  wire logic       clk_i,
    output logic      [1:0] pin_o
);
    initial pin_o = 2'h0;
    // each level lasts 4 clocks so the synchroniser sees every edge
    task automatic pulse(input int ch, input int n);
        repeat (n) begin
            repeat (4) @(negedge clk_i);
            pin_o[ch] = 1'b1;
            repeat (4) @(negedge clk_i);
            pin_o[ch] = 1'b0;
        end
        repeat (6) @(negedge clk_i);
    endtask
endmodule // cap_pin_source
`default_nettype wire

// [test_counter_timer_capture_match.sv]
// self-checking bench for the counter/timer
`timescale 1ns/1ps
`default_nettype none
module test_counter_timer_capture_match;
    typedef struct packed {
        logic [31:0]       pre;
        logic [31:0]       m;
        logic              irq;
        ctm_pkg::ext_act_t act;
        logic              pin;
    } row_t;
    logic                      clk = 1'b0;
    logic                      nrst, en, swr, chan;
    ctm_pkg::count_src_t       src;
    logic [31:0]               pre, tc, pc, mx;
    logic [3:0][31:0]          mval;
    ctm_pkg::match_ctl_t [3:0] mctl;
    ctm_pkg::cap_ctl_t [1:0]   cctl;
    ctm_pkg::clr_ctl_t         clr;
    ctm_pkg::ext_act_t [1:0]   ext;
    logic [5:0]                iclr, irq;
    wire  [1:0]                pins;
    logic [1:0][31:0]          cv;
    logic                      run;
    logic [1:0]                mp, dma;
    int                        err_count = 0;
    int                        n_compared = 0;
    int                        cyc, pulses, lo;
    row_t rows [4] = '{'{32'h0, 32'h5, 1'b1, ctm_pkg::EXT_TOGGLE, 1'b1},
                       '{32'h2, 32'h4, 1'b0, ctm_pkg::EXT_HIGH, 1'b1},
                       '{32'h1, 32'h6, 1'b1, ctm_pkg::EXT_LOW, 1'b0},
                       '{32'h3, 32'h3, 1'b0, ctm_pkg::EXT_NOTHING, 1'b0}};

    always #2.5 clk = ~clk;

    counter_timer_capture_match i_counter_timer_capture_match (
        .clk_i(clk), .nrst_i(nrst), .enable_i(en), .sw_reset_i(swr), .count_src_i(src),
        .count_chan_i(chan), .prescale_i(pre), .match_val_i(mval), .match_ctl_i(mctl),
        .cap_ctl_i(cctl), .clr_ctl_i(clr), .ext_act_i(ext), .irq_clear_i(iclr), .cap_pin_i(pins),
        .timer_count_value_o(tc), .prescale_count_o(pc), .cap_val_o(cv), .irq_pending_o(irq),
        .running_o(run), .match_pin_o(mp), .dma_req_o(dma));
    cap_pin_source i_cap_pin_source (.clk_i(clk), .pin_o(pins));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic do_reset();
        nrst = 1'b0;
        en = 1'b0;
        swr = 1'b0;
        chan = 1'b0;
        src = ctm_pkg::SRC_BUS_CLK;
        pre = 32'h0;
        mval = '1;
        mctl = '0;
        cctl = '0;
        clr = '0;
        ext = '{ctm_pkg::EXT_NOTHING, ctm_pkg::EXT_NOTHING};
        iclr = 6'h00;
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
    endtask

    initial begin
        #50000;
        err_count++;
        summarize();
    end

    initial begin
        do_reset();
        check(tc, 32'h0);
        check(pc, 32'h0);
        check(32'({irq, run, mp, dma}), 32'h0);
        foreach (rows[r]) begin
            do_reset();
            pre = rows[r].pre;
            mval[0] = rows[r].m;
            mval[1] = rows[r].m - 32'h1;
            mctl[0] = '{rows[r].irq, 1'b0, 1'b1};
            ext = '{ctm_pkg::EXT_TOGGLE, rows[r].act};
            en = 1'b1;
            cyc = 0;
            pulses = 0;
            for (int k = 0; k < 300 && !(cyc > 0 && !run); k++) begin
                @(negedge clk);
                cyc += int'(run);
                pulses += int'(dma[0]) + int'(dma[1]);
            end
            lo = int'(rows[r].m * (rows[r].pre + 32'h1));
            check(tc, rows[r].m);
            check(32'(irq[1:0]), 32'(rows[r].irq));
            check(32'(mp), 32'({1'b1, rows[r].pin}));
            check(32'(pulses), 32'h2);
            check(32'(cyc >= lo - 1 && cyc <= lo + 3), 32'h1);
            $display("row %0d done", r);
        end
        // sweep the three edge-count modes
        for (int j = 1; j < 4; j++) begin
            do_reset();
            src = ctm_pkg::count_src_t'(j);
            cctl[1] = '{1'b1, 1'b0, 1'b1};
            en = 1'b1;
            repeat (2) @(negedge clk);
            i_cap_pin_source.pulse(0, 5);
            check(tc, (j == 3) ? 32'hA : 32'h5);
            i_cap_pin_source.pulse(1, 1);
            check(cv[1], (j == 3) ? 32'hA : 32'h5);
            check(cv[0], 32'h0);
            check(32'(irq[5:4]), 32'h2);
            iclr = 6'h20;
            @(negedge clk);
            iclr = 6'h00;
            @(negedge clk);
            check(32'(irq[5:4]), 32'h0);
            $display("counter mode %0d done", j);
        end
        do_reset();
        mval[0] = 32'h3;
        mctl[0] = '{1'b0, 1'b1, 1'b0};
        en = 1'b1;
        mx = 32'h0;
        pulses = 0;
        repeat (40) begin
            @(negedge clk);
            if (tc > mx) mx = tc;
            pulses += int'(dma[0]);
        end
        check(mx, 32'h3);
        check(32'(run), 32'h1);
        check(32'(pulses >= 8 && pulses <= 10), 32'h1);
        $display("reset match done");
        do_reset();
        clr = '{1'b1, 1'b1, 1'b0};
        en = 1'b1;
        repeat (50) @(negedge clk);
        i_cap_pin_source.pulse(1, 1);
        check(32'(tc < 32'h10), 32'h1);
        // capture on pin 0 with its interrupt left disabled
        cctl[0] = '{1'b0, 1'b0, 1'b1};
        i_cap_pin_source.pulse(0, 1);
        check(32'(cv[0] != 32'h0), 32'h1);
        check(32'(irq[4]), 32'h0);
        pre = 32'h7;
        repeat (4) @(negedge clk);
        check(32'(pc != 32'h0), 32'h1);
        swr = 1'b1;
        repeat (2) @(negedge clk);
        check(tc, 32'h0);
        check(pc, 32'h0);
        swr = 1'b0;
        $display("clear tests done");
        summarize();
    end
endmodule // test_counter_timer_capture_match

bind counter_timer_capture_match ctm_assertions i_ctm_assertions (
    .clk_i(clk_i), .nrst_i(nrst_i), .sw_reset_i(sw_reset_i), .prescale_i(prescale_i),
    .match_val_i(match_val_i), .match_ctl_i(match_ctl_i), .cap_ctl_i(cap_ctl_i), .clr_ctl_i(clr_ctl_i),
    .irq_clear_i(irq_clear_i), .timer_count_value_o(timer_count_value_o), .irq_pending_o(irq_pending_o),
    .running_o(running_o), .match_pin_o(match_pin_o), .dma_req_o(dma_req_o));
`default_nettype wire
